// file: interrupt_priority_regs.sv
// interrupt priority register bank: fifteen three-bit source levels behind axi4-lite
`timescale 1ns/1ps

// Behaviour
// - field code 111 gives the source level 7, the highest user level.
// - code 001 gives level 1; other codes give their binary value.
// - code 000 disables the source; it never raises a request.
// - every bit outside a priority field reads as zero.
// - every priority field bit can be read and written by software.
// - at reset each field loads binary 100.
// - fifth register holds external interrupt 1 in bits 2-0.
// - sixth register holds timer4 14-12, compare4 10-8, compare3 6-4.
// - seventh holds uart2 transmit 14-12, receive 10-8, ext int 2 6-4, timer5 2-0.
// - eighth holds serial2 event in 6-4 and fault in 2-0.
// - ninth holds capture5 14-12, capture4 10-8, capture3 6-4.
// - tenth holds compare5 in bits 6-4, rest zero.
// - eleventh holds parallel port in bits 6-4, rest zero.
// - after any reset every source sits at level 4.
module interrupt_priority_regs (
  // clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // axi4-lite write address and data
  input  wire logic [irq_prio_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [irq_prio_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [irq_prio_pkg::STRB_W-1:0]   s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]                        s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  // axi4-lite read
  input  wire logic [irq_prio_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic      [irq_prio_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic      [1:0]                        s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // sources and arbitration side
  input  wire logic [irq_prio_pkg::NUM_SOURCES-1:0] source_pending,
  output logic      [irq_prio_pkg::NUM_SOURCES-1:0] source_request,
  output irq_prio_pkg::level_set_type            levels
);
  import irq_prio_pkg::*;

  logic                         write_valid;
  write_cmd_type                write_cmd;
  logic [INDEX_W-1:0]           read_index;
  logic [REG_W-1:0]             read_word;
  logic [2:0]                   level_vec  [NUM_SOURCES];
  logic [NUM_SOURCES*3-1:0]     level_flat;
  logic [NUM_SOURCES-1:0]       zero_mask;

  // bus slave
  axi_lite_port bus_port (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .write_valid   (write_valid),
    .write_cmd     (write_cmd),
    .read_index    (read_index),
    .read_word     (read_word)
  );

  // one field per source, placed by the field table; byte lane gates the write
  for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_field
    localparam int LSB  = FIELD_LSB[i];
    localparam int LANE = LSB / 8;
    wire hit = write_valid && (write_cmd.index == FIELD_REG[i])
               && write_cmd.strb[LANE];

    priority_field field (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .write_en    (hit),
      .write_value (write_cmd.data[LSB +: 3]),
      .level       (level_vec[i])
    );

    assign level_flat[i*3 +: 3] = level_vec[i];
    assign zero_mask[i]         = (level_vec[i] == LEVEL_OFF);
  end

  // levels go straight from the field flops to the arbiter
  assign levels = level_set_type'(level_flat);

  // readback places each field at its bit position, all else zero
  always_comb begin
    read_word = '0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (FIELD_REG[i] == read_index) begin
        read_word[FIELD_LSB[i] +: 3] = level_vec[i];
      end
    end
  end

  // a zero field blocks its source from the arbiter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_request <= '0;
    end else begin
      source_request <= source_pending & ~zero_mask;
    end
  end

  // ---- checks on the bank ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic was_reset;
  always_ff @(posedge aclk) begin
    was_reset <= !aresetn;
  end

  wire wr5  = write_valid && write_cmd.index == IDX_EXT_INT1 && write_cmd.strb[0];
  wire wr6  = write_valid && write_cmd.index == IDX_TIMER4 && write_cmd.strb[1];
  wire wr7  = write_valid && write_cmd.index == IDX_UART2 && write_cmd.strb[1];
  wire wr9  = write_valid && write_cmd.index == IDX_CAPTURE && write_cmd.strb[1];
  wire wr10 = write_valid && write_cmd.index == IDX_COMPARE5 && write_cmd.strb[0];
  wire wr11 = write_valid && write_cmd.index == IDX_PARALLEL && write_cmd.strb[0];
  wire wr8  = write_valid && write_cmd.index == IDX_SERIAL2 && write_cmd.strb[0];

  // helper: implemented mask of the register being read
  logic [REG_W-1:0] read_mask;
  always_comb begin
    unique case (read_index)
      IDX_EXT_INT1: read_mask = MASK_EXT_INT1;
      IDX_TIMER4:   read_mask = MASK_TIMER4;
      IDX_UART2:    read_mask = MASK_UART2;
      IDX_SERIAL2:  read_mask = MASK_SERIAL2;
      IDX_CAPTURE:  read_mask = MASK_CAPTURE;
      IDX_COMPARE5: read_mask = MASK_COMPARE5;
      IDX_PARALLEL: read_mask = MASK_PARALLEL;
      default:      read_mask = '0;
    endcase
  end

  reset_level_a: assert property (
    was_reset |-> level_flat == {NUM_SOURCES{LEVEL_RESET}})
    else $error("source level not four after reset");

  disabled_source_a: assert property (
    |zero_mask |=> (source_request & $past(zero_mask)) == '0)
    else $error("disabled source raised a request");

  enabled_source_a: assert property (
    (levels.timer5_level == LEVEL_MAX || levels.timer5_level == LEVEL_MIN)
      && source_pending[7] |=> source_request[7])
    else $error("enabled source request lost");

  ext_int1_write_a: assert property (
    wr5 |=> levels.ext_int1_level == $past(write_cmd.data[2:0]))
    else $error("ext int 1 field not written");

  timer4_write_a: assert property (
    wr6 |=> levels.timer4_level == $past(write_cmd.data[14:12])
      && levels.compare4_level == $past(write_cmd.data[10:8]))
    else $error("sixth register fields misplaced");

  uart2_write_a: assert property (
    wr7 && write_cmd.strb[0] |=> levels.uart2_transmit_level == $past(write_cmd.data[14:12])
      && levels.ext_int2_level == $past(write_cmd.data[6:4])
      && levels.timer5_level == $past(write_cmd.data[2:0]))
    else $error("seventh register fields misplaced");

  serial2_write_a: assert property (
    wr8 |=> levels.serial2_event_level == $past(write_cmd.data[6:4])
      && levels.serial2_fault_level == $past(write_cmd.data[2:0]))
    else $error("eighth register fields misplaced");

  capture_write_a: assert property (
    wr9 |=> levels.capture5_level == $past(write_cmd.data[14:12])
      && levels.capture4_level == $past(write_cmd.data[10:8]))
    else $error("ninth register fields misplaced");

  compare5_write_a: assert property (
    wr10 |=> levels.compare5_level == $past(write_cmd.data[6:4]))
    else $error("compare5 field not written");

  parallel_write_a: assert property (
    wr11 |=> levels.parallel_port_level == $past(write_cmd.data[6:4]))
    else $error("parallel port field not written");

  unused_bits_a: assert property (
    (read_word & ~read_mask) == '0)
    else $error("unimplemented bit reads as one");

  readback_match_a: assert property (
    read_index == IDX_CAPTURE |-> read_word[6:4] == levels.capture3_level)
    else $error("readback differs from arbiter level");

  // main scenarios
  write_seen_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  read_seen_c:  cover property (s_axi_rvalid && s_axi_rready);
  disable_c:    cover property (zero_mask[0] && source_pending[0]);
  unmapped_c:   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule // interrupt_priority_regs

// file: irq_prio_pkg.sv
// shared constants, register map and carrier types for the priority register bank
package irq_prio_pkg;

  // widths
  localparam int NUM_SOURCES = 15;
  localparam int FIELD_W     = 3;
  localparam int REG_W       = 16;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int INDEX_W     = 4;
  localparam int STRB_W      = DATA_W / 8;

  // priority level codes
  localparam logic [2:0] LEVEL_OFF   = 3'h0;
  localparam logic [2:0] LEVEL_MIN   = 3'h1;
  localparam logic [2:0] LEVEL_MAX   = 3'h7;
  localparam logic [2:0] LEVEL_RESET = 3'h4;

  // register indices; byte address is four times the index
  localparam logic [INDEX_W-1:0] IDX_EXT_INT1  = 4'h5;
  localparam logic [INDEX_W-1:0] IDX_TIMER4    = 4'h6;
  localparam logic [INDEX_W-1:0] IDX_UART2     = 4'h7;
  localparam logic [INDEX_W-1:0] IDX_SERIAL2   = 4'h8;
  localparam logic [INDEX_W-1:0] IDX_CAPTURE   = 4'h9;
  localparam logic [INDEX_W-1:0] IDX_COMPARE5  = 4'hA;
  localparam logic [INDEX_W-1:0] IDX_PARALLEL  = 4'hB;
  localparam int                 ADDR_LSB      = 2;

  // implemented bits of each register
  localparam logic [REG_W-1:0] MASK_EXT_INT1 = 16'h0007;
  localparam logic [REG_W-1:0] MASK_TIMER4   = 16'h7770;
  localparam logic [REG_W-1:0] MASK_UART2    = 16'h7777;
  localparam logic [REG_W-1:0] MASK_SERIAL2  = 16'h0077;
  localparam logic [REG_W-1:0] MASK_CAPTURE  = 16'h7770;
  localparam logic [REG_W-1:0] MASK_COMPARE5 = 16'h0070;
  localparam logic [REG_W-1:0] MASK_PARALLEL = 16'h0070;

  // source numbering: 0 ext_int1, 1 timer4, 2 compare4, 3 compare3, 4 uart2_transmit,
  // 5 uart2_receive, 6 ext_int2, 7 timer5, 8 serial2_event, 9 serial2_fault,
  // 10 capture5, 11 capture4, 12 capture3, 13 compare5, 14 parallel_port
  localparam logic [INDEX_W-1:0] FIELD_REG [NUM_SOURCES] = '{
    4'h5, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h7,
    4'h8, 4'h8, 4'h9, 4'h9, 4'h9, 4'hA, 4'hB};
  localparam int FIELD_LSB [NUM_SOURCES] = '{
    0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 4, 4};

  // answer codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one register write as handed from the bus port to the bank
  typedef struct packed {
    logic [INDEX_W-1:0] index;
    logic [REG_W-1:0]   data;
    logic [STRB_W-1:0]  strb;
  } write_cmd_type;

  // every source level, field of source 0 at the bottom
  typedef struct packed {
    logic [2:0] parallel_port_level;
    logic [2:0] compare5_level;
    logic [2:0] capture3_level;
    logic [2:0] capture4_level;
    logic [2:0] capture5_level;
    logic [2:0] serial2_fault_level;
    logic [2:0] serial2_event_level;
    logic [2:0] timer5_level;
    logic [2:0] ext_int2_level;
    logic [2:0] uart2_receive_level;
    logic [2:0] uart2_transmit_level;
    logic [2:0] compare3_level;
    logic [2:0] compare4_level;
    logic [2:0] timer4_level;
    logic [2:0] ext_int1_level;
  } level_set_type;

endpackage

// file: priority_field.sv
// one three-bit priority field with its reset value
`timescale 1ns/1ps
module priority_field (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // write side
  input  wire logic       write_en,
  input  wire logic [2:0] write_value,
  // field value
  output logic      [2:0] level
);
  import irq_prio_pkg::*;

  // field loads level four at reset, then takes software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= LEVEL_RESET;
    end else if (write_en) begin
      level <= write_value;
    end
  end

endmodule // priority_field

// file: axi_lite_port.sv
// axi4-lite slave port that hands writes and read indices to the register bank
`timescale 1ns/1ps
module axi_lite_port (
  // clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  // write address and data
  input  wire logic [irq_prio_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [irq_prio_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [irq_prio_pkg::STRB_W-1:0]  s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  // write response
  output logic      [1:0]                       s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  // read address and data
  input  wire logic [irq_prio_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic      [irq_prio_pkg::DATA_W-1:0]  s_axi_rdata,
  output logic      [1:0]                       s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // bank side
  output logic                                  write_valid,
  output irq_prio_pkg::write_cmd_type           write_cmd,
  output logic      [irq_prio_pkg::INDEX_W-1:0] read_index,
  input  wire logic [irq_prio_pkg::REG_W-1:0]   read_word
);
  import irq_prio_pkg::*;

  logic                aw_held;
  logic                aw_ok;
  logic [INDEX_W-1:0]  aw_index;
  logic                w_held;
  logic [REG_W-1:0]    w_data;
  logic [STRB_W-1:0]   w_strb;

  // address decode: aligned word inside the register range
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [INDEX_W-1:0] idx;
    idx = a[ADDR_LSB +: INDEX_W];
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:ADDR_LSB+INDEX_W] == '0)
           && (idx >= IDX_EXT_INT1) && (idx <= IDX_PARALLEL);
  endfunction

  // handshakes and the write that fires once both halves are held
  wire aw_take    = s_axi_awvalid && s_axi_awready;
  wire w_take     = s_axi_wvalid && s_axi_wready;
  wire ar_take    = s_axi_arvalid && s_axi_arready;
  wire fire       = aw_held && w_held && !s_axi_bvalid;
  wire next_aw    = aw_held ? !fire : aw_take;
  wire next_w     = w_held ? !fire : w_take;
  wire next_bval  = fire || (s_axi_bvalid && !s_axi_bready);
  wire next_rval  = ar_take || (s_axi_rvalid && !s_axi_rready);
  wire ar_ok      = addr_mapped(s_axi_araddr);

  assign write_valid = fire && aw_ok;
  assign write_cmd   = '{index: aw_index, data: w_data, strb: w_strb};
  assign read_index  = s_axi_araddr[ADDR_LSB +: INDEX_W];

  // write channel state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_ok         <= 1'b0;
      aw_index      <= '0;
      w_held        <= 1'b0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_held       <= next_aw;
      w_held        <= next_w;
      s_axi_awready <= !next_aw && !next_bval;
      s_axi_wready  <= !next_w && !next_bval;
      s_axi_bvalid  <= next_bval;
      if (aw_take) begin
        aw_ok    <= addr_mapped(s_axi_awaddr);
        aw_index <= s_axi_awaddr[ADDR_LSB +: INDEX_W];
      end
      if (w_take) begin
        w_data <= s_axi_wdata[REG_W-1:0];
        w_strb <= s_axi_wstrb;
      end
      if (fire) begin
        s_axi_bresp <= aw_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // read channel: data captured at the address handshake, upper half zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rval;
      s_axi_rvalid  <= next_rval;
      if (ar_take) begin
        s_axi_rdata <= ar_ok ? {{(DATA_W-REG_W){1'b0}}, read_word} : '0;
        s_axi_rresp <= ar_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule // axi_lite_port

// file: interrupt_priority_regs_test.sv
// self-checking testbench for the interrupt priority register bank
`timescale 1ns/1ps
module interrupt_priority_regs_test;
  import irq_prio_pkg::*;

  // clock, reset and bus signals
  logic                   aclk;
  logic                   aresetn;
  logic [ADDR_W-1:0]      s_axi_awaddr;
  logic                   s_axi_awvalid;
  logic                   s_axi_awready;
  logic [DATA_W-1:0]      s_axi_wdata;
  logic [STRB_W-1:0]      s_axi_wstrb;
  logic                   s_axi_wvalid;
  logic                   s_axi_wready;
  logic [1:0]             s_axi_bresp;
  logic                   s_axi_bvalid;
  logic                   s_axi_bready;
  logic [ADDR_W-1:0]      s_axi_araddr;
  logic                   s_axi_arvalid;
  logic                   s_axi_arready;
  logic [DATA_W-1:0]      s_axi_rdata;
  logic [1:0]             s_axi_rresp;
  logic                   s_axi_rvalid;
  logic                   s_axi_rready;
  logic [NUM_SOURCES-1:0] source_pending;
  logic [NUM_SOURCES-1:0] source_request;
  level_set_type          levels;

  // expectation queues, counters and register shadow
  logic [33:0]            read_q [$];
  logic [1:0]             resp_q [$];
  int                     err_count;
  int                     compares;
  logic [31:0]            seed;
  logic [REG_W-1:0]       shadow [16];
  logic [REG_W-1:0]       mask_tbl [16];
  logic [INDEX_W-1:0]     reg_idx [7] = '{IDX_EXT_INT1, IDX_TIMER4, IDX_UART2, IDX_SERIAL2,
                                          IDX_CAPTURE, IDX_COMPARE5, IDX_PARALLEL};
  logic [REG_W-1:0]       reg_mask [7] = '{MASK_EXT_INT1, MASK_TIMER4, MASK_UART2, MASK_SERIAL2,
                                           MASK_CAPTURE, MASK_COMPARE5, MASK_PARALLEL};

  interrupt_priority_regs dut (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .source_pending (source_pending),
    .source_request (source_request),
    .levels         (levels)
  );

  // 100 ns clock
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  // xorshift random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // an address maps when aligned and inside the register table
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && a[7:6] == 2'h0 && mask_tbl[a[5:2]] != 16'h0;
  endfunction

  // expected level bus from the shadow
  function automatic logic [NUM_SOURCES*3-1:0] exp_levels();
    logic [NUM_SOURCES*3-1:0] v;
    for (int i = 0; i < NUM_SOURCES; i++) v[i*3 +: 3] = shadow[FIELD_REG[i]][FIELD_LSB[i] +: 3];
    return v;
  endfunction

  // every field back to binary 100
  task automatic reset_model();
    for (int i = 0; i < 16; i++) shadow[i] = mask_tbl[i] & 16'h4444;
  endtask

  // compare tasks, one per kind of result
  task automatic cmp_read(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t read got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t write response got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [59:0] got, input logic [59:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t requests and levels got %h expected %h", $time, got, exp);
    end
  endtask

  // monitor: each answer taken off the bus is matched against the oldest note
  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      cmp_read({s_axi_rresp, s_axi_rdata}, read_q.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      cmp_resp(s_axi_bresp, resp_q.pop_front());
    end
  end

  // one write; address and data offered together, response with random stall
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                           input logic [STRB_W-1:0] s);
    logic ok;
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    int   dly;
    ok = mapped(a);
    dly = int'(xs() % 4);
    if (ok) begin
      for (int b = 0; b < 2; b++) begin
        if (s[b]) shadow[a[5:2]][b*8 +: 8] = d[b*8 +: 8] & mask_tbl[a[5:2]][b*8 +: 8];
      end
    end
    resp_q.push_back(ok ? RESP_OKAY : RESP_SLVERR);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    b_hs = 1'b0;
    for (int n = 0; n < 60 && !b_hs; n++) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      b_hs  = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
      else if (n == dly) s_axi_bready <= 1'b1;
    end
    if (!b_hs) begin
      err_count++;
      $display("BAD %0t write never answered", $time);
    end
    @(posedge aclk);
  endtask

  // one read with random stall on the data channel
  task automatic axi_read(input logic [ADDR_W-1:0] a);
    logic ar_hs;
    logic r_hs;
    int   dly;
    dly = int'(xs() % 4);
    read_q.push_back(mapped(a) ? {RESP_OKAY, 16'h0, shadow[a[5:2]]} : {RESP_SLVERR, 32'h0});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    r_hs = 1'b0;
    for (int n = 0; n < 60 && !r_hs; n++) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs  = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
      else if (n == dly) s_axi_rready <= 1'b1;
    end
    if (!r_hs) begin
      err_count++;
      $display("BAD %0t read never answered", $time);
    end
    @(posedge aclk);
  endtask

  // random pending sources, then levels and gated requests one edge later
  task automatic check_outputs();
    logic [NUM_SOURCES*3-1:0] lv;
    logic [NUM_SOURCES-1:0]   rq;
    source_pending <= NUM_SOURCES'(xs());
    @(posedge aclk);
    @(negedge aclk);
    lv = exp_levels();
    for (int i = 0; i < NUM_SOURCES; i++) rq[i] = source_pending[i] && lv[i*3 +: 3] != 3'h0;
    cmp_out({source_request, levels}, {rq, lv});
    @(posedge aclk);
  endtask

  // read every register and check the level outputs
  task automatic read_all();
    for (int r = 0; r < 7; r++) axi_read({2'h0, reg_idx[r], 2'h0});
    check_outputs();
  endtask

  // verdict and end of run
  task automatic end_sim();
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("BAD %0t timeout", $time);
    end_sim();
  end

  // main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] s;
    seed = 32'h9471BFA6;
    err_count = 0;
    compares = 0;
    for (int i = 0; i < 16; i++) mask_tbl[i] = 16'h0;
    for (int r = 0; r < 7; r++) mask_tbl[reg_idx[r]] = reg_mask[r];
    reset_model();
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    source_pending <= '0;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    read_all();
    // every code on one field
    for (int c = 0; c < 8; c++) begin
      axi_write({2'h0, IDX_EXT_INT1, 2'h0}, 32'(c), 4'hF);
      check_outputs();
    end
    // all ones, then random data and strobes with read-back
    for (int r = 0; r < 7; r++) axi_write({2'h0, reg_idx[r], 2'h0}, 32'hFFFFFFFF, 4'hF);
    read_all();
    for (int k = 0; k < 40; k++) begin
      d = xs();
      s = xs();
      axi_write({2'h0, reg_idx[s % 7], 2'h0}, d, s[7:4]);
      axi_read({2'h0, reg_idx[s % 7], 2'h0});
      if (k % 8 == 0) check_outputs();
    end
    // unmapped and unaligned places
    axi_write(8'h10, 32'h00000000, 4'hF);
    axi_write(8'h19, 32'h00000000, 4'hF);
    axi_write(8'h40, 32'h00000000, 4'hF);
    axi_read(8'h00);
    axi_read(8'h2E);
    axi_read(8'hFC);
    read_all();
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_model();
    @(posedge aclk);
    read_all();
    repeat (5) @(posedge aclk);
    if (read_q.size() + resp_q.size() != 0) begin
      err_count++;
      $display("BAD %0t answers missing", $time);
    end
    end_sim();
  end

endmodule // interrupt_priority_regs_test
